// ### inc/rci_pkg.sv
// Package of constants and types for the reset-cause and interrupt logic
package rci_pkg;
  // ----------------------------------------
  // Register map (byte addresses, word index times four)
  // ----------------------------------------
  localparam logic [7:0] WAKE_CTRL_IDX = 8'h0e;
  localparam logic [7:0] IRQ_MASK_IDX = 8'h0f;
  localparam logic [7:0] IRQ_FLAG_IDX = 8'h3f;
  localparam logic [7:0] CAUSE_IDX = 8'h03;
  localparam logic [9:0] WAKE_CTRL_ADDR = {WAKE_CTRL_IDX, 2'b00};
  localparam logic [9:0] IRQ_MASK_ADDR = {IRQ_MASK_IDX, 2'b00};
  localparam logic [9:0] IRQ_FLAG_ADDR = {IRQ_FLAG_IDX, 2'b00};
  localparam logic [9:0] CAUSE_ADDR = {CAUSE_IDX, 2'b00};
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int OPEN_DRAIN_POS = 6;
  localparam int WDOG_EN_POS = 5;
  localparam int SLEEP_CTRL_POS = 4;
  localparam int OSC_OUT_POS = 3;
  localparam int WAKE_DIS_POS = 0;
  localparam int EXT_IRQ_POS = 3;
  localparam int TMR_IRQ_POS = 0;
  localparam int TIMEOUT_POS = 4;
  localparam int PDOWN_POS = 3;
  localparam int PIN_CHG_POS = 1;
  // ----------------------------------------
  // Reset values and writable masks
  // ----------------------------------------
  localparam logic [7:0] WAKE_CTRL_RST = 8'h31;
  localparam logic [7:0] WAKE_CTRL_WMASK = 8'h79;
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;
  localparam logic [7:0] IRQ_MASK_WMASK = 8'h09;
  localparam logic [7:0] IRQ_FLAG_WMASK = 8'h0b;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // ----------------------------------------
  // Fetch vectors
  // ----------------------------------------
  localparam logic [10:0] HW_VECTOR = 11'h001;
  localparam logic [10:0] SW_VECTOR = 11'h002;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {RCI_RUN, RCI_SLEEP1, RCI_SLEEP2} rci_mode_t;
endpackage

// ### logic/rci_sync.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module rci_sync
  import rci_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  typedef struct packed
  {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } rci_sync_state_t;

  rci_sync_state_t s_reg;
  rci_sync_state_t s_next;

  // First stage feeds only the second
  always_comb
  begin
    s_next.meta = din;
    s_next.sync = s_reg.meta;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    // Idle-high reset, so released pins show no false edge
    if (!rstn)
      s_reg <= '1;
    else
      s_reg <= s_next;
  end

  assign dout = s_reg.sync;
endmodule // rci_sync

// ### logic/rci_top.sv
// Reset-cause flags, wake control and interrupt control of the core
`timescale 1ns/10ps
// Behaviour
// - Reset comes from power-on, reset pin low-high pulse, or watchdog time-out.
// - Power-on sets both timeout and power-down flags.
// - Reset pin while running keeps both flags.
// - Reset pin wake from sleep 1 sets timeout, clears power-down.
// - Reset pin wake from sleep 2 keeps both flags.
// - Watchdog time-out while running clears timeout, keeps power-down.
// - Watchdog wake from sleep 1 clears both flags.
// - Watchdog wake from sleep 2 clears timeout, keeps power-down.
// - Pin-change wake from sleep 2 keeps both flags.
// - Watchdog clear sets both flags; sleep sets timeout, clears power-down.
// - Pin-change wake resumes at next instruction at once; a falling sleep-control bit also pulses resume.
// - Any reset loads wake control and clears mask; pin-change wake keeps them.
// - Two hardware sources: timer overflow and external interrupt pin.
// - Each request latches into a flag; mask register holds enables.
// - Enable op sets global enable; disable op clears it.
// - Enabled hardware interrupt fetches next instruction from 001H.
// - Flags except pin-change set regardless of mask and global enable.
// - Effective request is flags AND mask bits.
// - Return-from-handler ends service and sets global enable.
// - Enabled software interrupt fetches next instruction from 002H.
module rci_top
  import rci_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Pins, asynchronous
  input wire logic reset_pin_n,
  input wire logic ext_irq_pin_n,
  input wire logic pin_change,
  // Sequencer events, same clock
  input wire logic timer_counter_overflow,
  input wire logic watchdog_timeout,
  input wire logic enable_irqs_op,
  input wire logic disable_irqs_op,
  input wire logic return_from_handler_op,
  input wire logic watchdog_clear_op,
  input wire logic enter_sleep_op,
  input wire logic sleep2_select,
  input wire logic soft_irq_op,
  // Sequencer controls
  output logic core_reset,
  output logic core_sleeping,
  output logic resume_fetch,
  output logic vector_load,
  output logic [10:0] vector_addr,
  output logic global_irq_enable,
  // Register file outputs
  output logic open_drain_enable,
  output logic watchdog_enable_bit,
  output logic oscillator_output_select,
  output logic wake_disable_bit,
  // Avalon-MM slave
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed
  {
    rci_mode_t mode;
    logic timeout_flag;
    logic pdown_flag;
    logic [7:0] wake_ctrl;
    logic [7:0] irq_mask;
    logic [7:0] irq_flag;
    logic gie;
    logic rst_pin_d;
    logic ext_pin_d;
    logic core_reset;
    logic resume;
    logic vec_load;
    logic [10:0] vec_addr;
    logic bus_wait;
    logic asleep;
    logic [31:0] rdata;
  } rci_state_t;

  rci_state_t s_reg;
  rci_state_t s_next;
  logic rst_pin_s;
  logic ext_pin_s;
  logic pin_chg_s;
  logic pin_chg_n_s;
  logic rst_pin_rise;
  logic ext_pin_fall;
  logic [7:0] eff_req;
  logic sleeping;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  rci_sync #(.WIDTH(3)) u_sync
  (
    .clk(clk),
    .rstn(rstn),
    // Pin change inverted so every stage idles high
    .din({reset_pin_n, ext_irq_pin_n, !pin_change}),
    .dout({rst_pin_s, ext_pin_s, pin_chg_n_s})
  );

  assign pin_chg_s = !pin_chg_n_s;

  function automatic logic addr_hit(input logic [9:0] a, input logic [9:0] r);
    addr_hit = (a == r);
  endfunction

  // Reset pin acts on the release edge, matching a low-high pulse
  assign rst_pin_rise = rst_pin_s && !s_reg.rst_pin_d;
  assign ext_pin_fall = !ext_pin_s && s_reg.ext_pin_d;
  assign eff_req = s_reg.irq_flag & s_reg.irq_mask;
  assign sleeping = (s_reg.mode != RCI_RUN);

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.rst_pin_d = rst_pin_s;
    s_next.ext_pin_d = ext_pin_s;
    s_next.core_reset = 1'b0;
    s_next.resume = 1'b0;
    s_next.vec_load = 1'b0;
    s_next.bus_wait = 1'b1;
    if (enable_irqs_op)
      s_next.gie = 1'b1;
    if (disable_irqs_op)
      s_next.gie = 1'b0;
    if (return_from_handler_op)
      s_next.gie = 1'b1;
    if (watchdog_clear_op)
    begin
      s_next.timeout_flag = 1'b1;
      s_next.pdown_flag = 1'b1;
    end
    if (enter_sleep_op && !sleeping)
    begin
      s_next.timeout_flag = 1'b1;
      s_next.pdown_flag = 1'b0;
      s_next.mode = sleep2_select ? RCI_SLEEP2 : RCI_SLEEP1;
    end
    // Bus wait cycle: read data captured, answer stands next cycle
    if ((avs_read || avs_write) && s_reg.bus_wait)
    begin
      s_next.bus_wait = 1'b0;
      s_next.rdata = '0;
      if (addr_hit(avs_address, WAKE_CTRL_ADDR))
        s_next.rdata[7:0] = s_reg.wake_ctrl;
      else if (addr_hit(avs_address, IRQ_MASK_ADDR))
        s_next.rdata[7:0] = s_reg.irq_mask;
      else if (addr_hit(avs_address, IRQ_FLAG_ADDR))
        s_next.rdata[7:0] = s_reg.irq_flag;
      else if (addr_hit(avs_address, CAUSE_ADDR))
      begin
        s_next.rdata[TIMEOUT_POS] = s_reg.timeout_flag;
        s_next.rdata[PDOWN_POS] = s_reg.pdown_flag;
      end
    end
    // Write lands at the accept edge; loses to hardware sets below
    if (avs_write && !s_reg.bus_wait)
    begin
      if (addr_hit(avs_address, WAKE_CTRL_ADDR))
        s_next.wake_ctrl = avs_writedata[7:0] & WAKE_CTRL_WMASK;
      else if (addr_hit(avs_address, IRQ_MASK_ADDR))
        s_next.irq_mask = avs_writedata[7:0] & IRQ_MASK_WMASK;
      else if (addr_hit(avs_address, IRQ_FLAG_ADDR))
        s_next.irq_flag = avs_writedata[7:0] & IRQ_FLAG_WMASK;
    end
    // resume also pulses when software drops sleep bit
    if (s_reg.wake_ctrl[SLEEP_CTRL_POS] && !s_next.wake_ctrl[SLEEP_CTRL_POS])
      s_next.resume = 1'b1;
    if (timer_counter_overflow)
      s_next.irq_flag[TMR_IRQ_POS] = 1'b1;
    if (ext_pin_fall)
      s_next.irq_flag[EXT_IRQ_POS] = 1'b1;
    // Pin-change flag only when the wake-disable bit in wake control is clear
    if (pin_chg_s && !s_reg.wake_ctrl[WAKE_DIS_POS])
      s_next.irq_flag[PIN_CHG_POS] = 1'b1;
    if (|eff_req && s_reg.gie && !sleeping)
    begin
      s_next.gie = 1'b0;
      s_next.vec_load = 1'b1;
      s_next.vec_addr = HW_VECTOR;
    end
    else if (soft_irq_op && s_reg.gie)
    begin
      s_next.gie = 1'b0;
      s_next.vec_load = 1'b1;
      s_next.vec_addr = SW_VECTOR;
    end
    // pin-change wake keeps flags and registers
    if (s_reg.mode == RCI_SLEEP2 && pin_chg_s && !s_reg.wake_ctrl[WAKE_DIS_POS])
    begin
      s_next.mode = RCI_RUN;
      s_next.resume = 1'b1;
    end
    if (rst_pin_rise || watchdog_timeout)
    begin
      unique case (s_reg.mode)
        RCI_RUN:
        begin
          s_next.timeout_flag = rst_pin_rise ? s_reg.timeout_flag : 1'b0;
          s_next.pdown_flag = s_reg.pdown_flag;
        end
        RCI_SLEEP1:
        begin
          s_next.timeout_flag = rst_pin_rise;
          s_next.pdown_flag = 1'b0;
        end
        RCI_SLEEP2:
        begin
          s_next.timeout_flag = rst_pin_rise ? s_reg.timeout_flag : 1'b0;
          s_next.pdown_flag = s_reg.pdown_flag;
        end
        default:
        begin
          s_next.timeout_flag = s_reg.timeout_flag;
          s_next.pdown_flag = s_reg.pdown_flag;
        end
      endcase
      s_next.wake_ctrl = WAKE_CTRL_RST;
      s_next.irq_mask = IRQ_MASK_RST;
      s_next.irq_flag = '0;
      s_next.gie = 1'b0;
      s_next.mode = RCI_RUN;
      s_next.core_reset = 1'b1;
      s_next.vec_load = 1'b0;
      s_next.resume = 1'b0;
    end
    s_next.asleep = (s_next.mode != RCI_RUN);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_reg <= '0;
      s_reg.timeout_flag <= 1'b1;
      s_reg.pdown_flag <= 1'b1;
      s_reg.wake_ctrl <= WAKE_CTRL_RST;
      s_reg.irq_mask <= IRQ_MASK_RST;
      s_reg.rst_pin_d <= 1'b1;
      s_reg.ext_pin_d <= 1'b1;
      s_reg.core_reset <= 1'b1;
      s_reg.bus_wait <= 1'b1;
      s_reg.mode <= RCI_RUN;
    end
    else
      s_reg <= s_next;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign core_reset = s_reg.core_reset;
  assign core_sleeping = s_reg.asleep;
  assign resume_fetch = s_reg.resume;
  assign vector_load = s_reg.vec_load;
  assign vector_addr = s_reg.vec_addr;
  assign global_irq_enable = s_reg.gie;
  assign open_drain_enable = s_reg.wake_ctrl[OPEN_DRAIN_POS];
  assign watchdog_enable_bit = s_reg.wake_ctrl[WDOG_EN_POS];
  assign oscillator_output_select = s_reg.wake_ctrl[OSC_OUT_POS];
  assign wake_disable_bit = s_reg.wake_ctrl[WAKE_DIS_POS];
  assign avs_readdata = s_reg.rdata;
  // Idles high; drops only in the cycle the answer stands
  assign avs_waitrequest = s_reg.bus_wait;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  vector_hw_a: assert property (@(posedge clk) disable iff (!rstn)
    (|eff_req && s_reg.gie && !sleeping && !rst_pin_rise && !watchdog_timeout)
    |=> (vector_load && vector_addr == HW_VECTOR))
    else $error("hardware vector not taken");
  vector_sw_a: assert property (@(posedge clk) disable iff (!rstn)
    (soft_irq_op && s_reg.gie && !(|eff_req && !sleeping)
      && !rst_pin_rise && !watchdog_timeout)
    |=> (vector_load && vector_addr == SW_VECTOR))
    else $error("software vector not taken");
  pin_wake_a: assert property (@(posedge clk) disable iff (!rstn)
    (s_reg.mode == RCI_SLEEP2 && pin_chg_s && !s_reg.wake_ctrl[WAKE_DIS_POS]
      && !rst_pin_rise && !watchdog_timeout && !watchdog_clear_op)
    |=> (s_reg.timeout_flag == $past(s_reg.timeout_flag)
      && s_reg.pdown_flag == $past(s_reg.pdown_flag) && resume_fetch))
    else $error("pin-change wake changed flags");
  gie_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    vector_load |-> !global_irq_enable)
    else $error("global enable left set on entry");
  gie_set_a: assert property (@(posedge clk) disable iff (!rstn)
    (enable_irqs_op && !rst_pin_rise && !watchdog_timeout && !(|eff_req && s_reg.gie))
    |=> global_irq_enable)
    else $error("enable op ignored");
  gie_off_a: assert property (@(posedge clk) disable iff (!rstn)
    (disable_irqs_op && !enable_irqs_op && !return_from_handler_op) |=> !global_irq_enable)
    else $error("disable op ignored");
  tmr_flag_a: assert property (@(posedge clk) disable iff (!rstn)
    (timer_counter_overflow && !rst_pin_rise && !watchdog_timeout)
    |=> s_reg.irq_flag[TMR_IRQ_POS])
    else $error("timer flag not set");
  wdt_run_a: assert property (@(posedge clk) disable iff (!rstn)
    (watchdog_timeout && s_reg.mode == RCI_RUN)
    |=> (!s_reg.timeout_flag && s_reg.pdown_flag == $past(s_reg.pdown_flag)))
    else $error("watchdog flags wrong");
  sleep_flags_a: assert property (@(posedge clk) disable iff (!rstn)
    (enter_sleep_op && !sleeping && !rst_pin_rise && !watchdog_timeout)
    |=> (s_reg.timeout_flag && !s_reg.pdown_flag && core_sleeping))
    else $error("sleep flags wrong");
  reset_regs_a: assert property (@(posedge clk) disable iff (!rstn)
    watchdog_timeout |=> (s_reg.wake_ctrl == WAKE_CTRL_RST && s_reg.irq_mask == IRQ_MASK_RST
      && core_reset))
    else $error("reset values not loaded");
endmodule // rci_top

// ### tb/rci_seq_model.sv
// Sequencer model that follows the fetch redirects of the block
`timescale 1ns/10ps
module rci_seq_model
  import rci_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Redirects from the block
  input wire logic core_reset,
  input wire logic resume_fetch,
  input wire logic vector_load,
  input wire logic [10:0] vector_addr,
  // Fetch state seen by the bench
  output logic [10:0] pc,
  output logic [7:0] wakes
);
  // ----------
  // Fetch pointer
  // ----------
  // vector fetch
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pc <= 11'h000;
      wakes <= 8'h00;
    end
    else if (core_reset)
      pc <= 11'h000;
    else if (vector_load)
      pc <= vector_addr;
    else if (resume_fetch)
    begin
      pc <= pc + 11'h001;
      wakes <= wakes + 8'h01;
    end
  end
endmodule // rci_seq_model

// ### tb/rci_tb.sv
// Self-checking bench for the reset-cause and interrupt logic
`timescale 1ns/10ps
module tb
  import rci_pkg::*;
();
  // ----------
  // Signals
  // ----------
  logic clk, rstn, slp2, rd, wr, core_reset, sleeping, resume, vload, gie, od, wde, oso, wkd;
  logic wreq;
  // Pins: reset, external irq, pin change
  logic [2:0] pins;
  // Ops: tmr, wdog, eni, disable_irqs_op, return_from_handler_op, watchdog_clear_op, sleep, soft
  logic [7:0] ev;
  logic [9:0] addr;
  logic [31:0] wdata, rdata;
  logic [10:0] vaddr, pc;
  logic [7:0] wakes;
  int err_count, checks_done, nrst, n0;
  // ----------
  // Design and sequencer model
  // ----------
  rci_top dut
  (
    .clk(clk), .rstn(rstn), .reset_pin_n(pins[2]), .ext_irq_pin_n(pins[1]),
    .pin_change(pins[0]), .timer_counter_overflow(ev[0]), .watchdog_timeout(ev[1]),
    .enable_irqs_op(ev[2]), .disable_irqs_op(ev[3]), .return_from_handler_op(ev[4]),
    .watchdog_clear_op(ev[5]), .enter_sleep_op(ev[6]), .sleep2_select(slp2),
    .soft_irq_op(ev[7]), .core_reset(core_reset), .core_sleeping(sleeping),
    .resume_fetch(resume), .vector_load(vload), .vector_addr(vaddr),
    .global_irq_enable(gie), .open_drain_enable(od), .watchdog_enable_bit(wde),
    .oscillator_output_select(oso), .wake_disable_bit(wkd), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata),
    .avs_waitrequest(wreq)
  );
  rci_seq_model seq
  (
    .clk(clk), .rstn(rstn), .core_reset(core_reset), .resume_fetch(resume),
    .vector_load(vload), .vector_addr(vaddr), .pc(pc), .wakes(wakes)
  );
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
    if (core_reset === 1'b1)
      nrst++;
  // ----------
  // Tasks
  // ----------
  task automatic tally_and_finish();
    if (err_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Request held until the edge that sees waitrequest low
  task automatic bus(input logic [9:0] a, input logic w, input logic [7:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    rd <= !w;
    wr <= w;
    wdata <= {24'h00_0000, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wreq !== 1'b0 && n < 20);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wreq !== 1'b0)
    begin
      err_count++;
      $display("[ERR] %0t bus timeout", $time);
      tally_and_finish();
    end
  endtask
  task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 8'h00, q);
    chk(q, {24'h00_0000, e});
  endtask
  function automatic logic [7:0] tp(input logic [1:0] v);
    return {3'b000, v, 3'b000};
  endfunction
  task automatic fire(input int i);
    @(posedge clk);
    ev <= 8'h01 << i;
    @(posedge clk);
    ev <= 8'h00;
    repeat (3) @(posedge clk);
  endtask
  // Pins pass a synchroniser, so each pulse is held several cycles
  task automatic pin(input int k);
    @(posedge clk);
    pins <= pins ^ (3'b001 << k);
    repeat (4) @(posedge clk);
    pins <= pins ^ (3'b001 << k);
    repeat (6) @(posedge clk);
  endtask
  // ----------
  // Sequence
  // ----------
  initial
  begin
    {rstn, slp2, rd, wr} = 4'h0;
    pins = 3'b110;
    ev = 8'h00;
    addr = 10'h000;
    wdata = 32'h0000_0000;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    rd_chk(WAKE_CTRL_ADDR, 8'h31);
    rd_chk(IRQ_MASK_ADDR, 8'h00);
    rd_chk(CAUSE_ADDR, tp(2'b11));
    chk(32'({od, wde, oso, wkd}), 32'h5);
    wr_reg(10'h004, 8'hff);
    rd_chk(10'h004, 8'h00);
    wr_reg(WAKE_CTRL_ADDR, 8'hff);
    rd_chk(WAKE_CTRL_ADDR, 8'h79);
    wr_reg(IRQ_MASK_ADDR, 8'hff);
    rd_chk(IRQ_MASK_ADDR, 8'h09);
    fire(5);
    rd_chk(CAUSE_ADDR, tp(2'b11));
    n0 = nrst;
    fire(1);
    chk(nrst - n0, 1);
    rd_chk(CAUSE_ADDR, tp(2'b01));
    rd_chk(WAKE_CTRL_ADDR, 8'h31);
    rd_chk(IRQ_MASK_ADDR, 8'h00);
    n0 = nrst;
    pin(2);
    chk(nrst - n0, 1);
    rd_chk(CAUSE_ADDR, tp(2'b01));
    fire(6);
    chk(32'(sleeping), 32'h1);
    rd_chk(CAUSE_ADDR, tp(2'b10));
    fire(1);
    rd_chk(CAUSE_ADDR, tp(2'b00));
    fire(6);
    pin(2);
    rd_chk(CAUSE_ADDR, tp(2'b10));
    slp2 <= 1'b1;
    fire(6);
    fire(1);
    rd_chk(CAUSE_ADDR, tp(2'b00));
    fire(6);
    pin(2);
    rd_chk(CAUSE_ADDR, tp(2'b10));
    wr_reg(WAKE_CTRL_ADDR, 8'h70);
    wr_reg(IRQ_MASK_ADDR, 8'h09);
    wr_reg(IRQ_FLAG_ADDR, 8'h00);
    fire(6);
    n0 = wakes;
    pin(0);
    chk(wakes - n0, 1);
    chk(32'({sleeping, od}), 32'h1);
    rd_chk(CAUSE_ADDR, tp(2'b10));
    rd_chk(IRQ_MASK_ADDR, 8'h09);
    rd_chk(IRQ_FLAG_ADDR, 8'h02);
    wr_reg(IRQ_FLAG_ADDR, 8'h00);
    fire(0);
    rd_chk(IRQ_FLAG_ADDR, 8'h01);
    fire(2);
    chk(32'({pc, gie}), 32'h2);
    wr_reg(IRQ_FLAG_ADDR, 8'h00);
    fire(4);
    chk(32'(gie), 32'h1);
    wr_reg(IRQ_MASK_ADDR, 8'h01);
    pin(1);
    rd_chk(IRQ_FLAG_ADDR, 8'h08);
    chk(32'(gie), 32'h1);
    wr_reg(IRQ_MASK_ADDR, 8'h09);
    repeat (3) @(posedge clk);
    chk(32'(gie), 32'h0);
    wr_reg(IRQ_FLAG_ADDR, 8'h00);
    fire(4);
    fire(3);
    chk(32'(gie), 32'h0);
    fire(2);
    chk(32'(gie), 32'h1);
    fire(7);
    chk(32'(pc), 32'h2);
    tally_and_finish();
  end
endmodule // tb
